/* core/dual_timer_event_counter.v */
// How it works
// - Eight-bit up-counter, pin or divided clock
// - Sixteen-bit up-counter, pin or divided clock
// - Short location: write preload, read count
// - Wide low write fills holding buffer only
// - Wide high write loads both preload bytes
// - Wide high read captures low into buffer
// - Wide low read returns holding buffer
// - Mode bits: event, timer, pulse width
// - Overflow reloads preload and sets flag
// - Pulse mode counts between edges, clears run
// - Edge bit chooses rising or falling
// - One measurement per run enable setting
// - Pulse mode overflow reloads and flags too
// - Run bit cleared only by software otherwise
// - Overflow wakes the halted device
// - Interrupt enable gates overflow request
// - Stopped counter takes written value
// - Running counter keeps counting, preload only
// - Reading count blocks its count clock
// - Control bits 0-2 and 5 read zero
`timescale 1ns/1ns
`default_nettype none
`include "dual_timer_regs.vh"
module dual_timer_event_counter (
    input  wire       clk,
    input  wire       rst_b,
    input  wire [7:0] bus_addr,
    input  wire [7:0] bus_wdata,
    input  wire       bus_wr,
    input  wire       bus_rd,
    output reg  [7:0] bus_rdata,
    input  wire       short_counter_pin,
    input  wire       wide_counter_pin,
    input  wire       short_irq_enable,
    input  wire       wide_irq_enable,
    input  wire       short_overflow_clear,
    input  wire       wide_overflow_clear,
    output reg        short_overflow_flag,
    output reg        wide_overflow_flag,
    output wire       short_irq,
    output wire       wide_irq,
    output wire       wake_up
);
    reg  [1:0]  prescale;
    reg  [7:0]  short_counter_control;
    reg  [7:0]  wide_counter_control;
    reg  [7:0]  low_buffer;
    reg  [7:0]  next_rdata;
    wire        tick;
    wire        short_level;
    wire        short_rise;
    wire        short_fall;
    wire        wide_level;
    wire        wide_rise;
    wire        wide_fall;
    wire [7:0]  short_count;
    wire [7:0]  short_preload;
    wire [15:0] wide_count;
    wire [15:0] wide_preload;
    wire        short_ovf;
    wire        wide_ovf;
    wire        short_done;
    wire        wide_done;
    wire        rd_short;
    wire        rd_wide_high;
    wire        wr_short;
    wire        wr_wide_high;
    wire        wr_wide_low;
    wire        wr_short_ctl;
    wire        wr_wide_ctl;

    assign rd_short     = bus_rd & (bus_addr == `ADDR_SHORT_VALUE);
    assign rd_wide_high = bus_rd & (bus_addr == `ADDR_WIDE_HIGH);
    assign wr_short     = bus_wr & (bus_addr == `ADDR_SHORT_VALUE);
    assign wr_wide_high = bus_wr & (bus_addr == `ADDR_WIDE_HIGH);
    assign wr_wide_low  = bus_wr & (bus_addr == `ADDR_WIDE_LOW);
    assign wr_short_ctl = bus_wr & (bus_addr == `ADDR_SHORT_CONTROL);
    assign wr_wide_ctl  = bus_wr & (bus_addr == `ADDR_WIDE_CONTROL);

    // System clock divided by four
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            prescale <= 2'b00;
        else
            prescale <= prescale + 2'b01;
    end
    assign tick = (prescale == `PRESCALE_LAST);

    input_edge_sync u_short_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .pin   (short_counter_pin),
        .level (short_level),
        .rise  (short_rise),
        .fall  (short_fall)
    );

    input_edge_sync u_wide_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .pin   (wide_counter_pin),
        .level (wide_level),
        .rise  (wide_rise),
        .fall  (wide_fall)
    );

    count_channel #(.WIDTH(8)) u_short (
        .clk          (clk),
        .rst_b        (rst_b),
        .control      (short_counter_control),
        .tick         (tick),
        .pin_level    (short_level),
        .pin_rise     (short_rise),
        .pin_fall     (short_fall),
        .hold         (rd_short),
        .preload_we   (wr_short),
        .preload_data (bus_wdata),
        .count        (short_count),
        .preload      (short_preload),
        .overflow     (short_ovf),
        .pulse_done   (short_done)
    );

    count_channel #(.WIDTH(16)) u_wide (
        .clk          (clk),
        .rst_b        (rst_b),
        .control      (wide_counter_control),
        .tick         (tick),
        .pin_level    (wide_level),
        .pin_rise     (wide_rise),
        .pin_fall     (wide_fall),
        .hold         (rd_wide_high),
        .preload_we   (wr_wide_high),
        .preload_data ({bus_wdata, low_buffer}),
        .count        (wide_count),
        .preload      (wide_preload),
        .overflow     (wide_ovf),
        .pulse_done   (wide_done)
    );

    // Control registers; hardware clears run only at pulse end
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            short_counter_control <= `CTL_RESET;
            wide_counter_control  <= `CTL_RESET;
        end else begin
            if (wr_short_ctl)
                short_counter_control <= bus_wdata & `CTL_IMPL_MASK;
            else if (short_done)
                short_counter_control[`CTL_RUN_BIT] <= 1'b0;
            if (wr_wide_ctl)
                wide_counter_control <= bus_wdata & `CTL_IMPL_MASK;
            else if (wide_done)
                wide_counter_control[`CTL_RUN_BIT] <= 1'b0;
        end
    end

    // Low-byte holding buffer
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            low_buffer <= 8'h00;
        else if (rd_wide_high)
            low_buffer <= wide_count[7:0];
        else if (wr_wide_low)
            low_buffer <= bus_wdata;
    end

    // Overflow flags: set wins over clear
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            short_overflow_flag <= 1'b0;
            wide_overflow_flag  <= 1'b0;
        end else begin
            if (short_ovf)
                short_overflow_flag <= 1'b1;
            else if (short_overflow_clear)
                short_overflow_flag <= 1'b0;
            if (wide_ovf)
                wide_overflow_flag <= 1'b1;
            else if (wide_overflow_clear)
                wide_overflow_flag <= 1'b0;
        end
    end

    assign short_irq = short_overflow_flag & short_irq_enable;
    assign wide_irq  = wide_overflow_flag & wide_irq_enable;
    assign wake_up   = short_ovf | wide_ovf;

    // Read data mux
    always @* begin
        next_rdata = 8'h00;
        case (bus_addr)
            `ADDR_SHORT_VALUE:   next_rdata = short_count;
            `ADDR_SHORT_CONTROL: next_rdata = short_counter_control;
            `ADDR_WIDE_HIGH:     next_rdata = wide_count[15:8];
            `ADDR_WIDE_LOW:      next_rdata = low_buffer;
            `ADDR_WIDE_CONTROL:  next_rdata = wide_counter_control;
            default:             next_rdata = 8'h00;
        endcase
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            bus_rdata <= 8'h00;
        else if (bus_rd)
            bus_rdata <= next_rdata;
    end
endmodule
`default_nettype wire

/* core/dual_timer_regs.vh */
`ifndef DUAL_TIMER_REGS_VH
`define DUAL_TIMER_REGS_VH

// Data memory addresses
`define ADDR_SHORT_VALUE     8'h0d
`define ADDR_SHORT_CONTROL   8'h0e
`define ADDR_WIDE_HIGH       8'h0f
`define ADDR_WIDE_LOW        8'h10
`define ADDR_WIDE_CONTROL    8'h11

// Control register fields
`define CTL_EDGE_BIT         3
`define CTL_RUN_BIT          4
`define CTL_MODE_LSB         6
`define CTL_MODE_MSB         7
`define CTL_IMPL_MASK        8'hd8
`define CTL_RESET            8'h00

// Mode encodings
`define MODE_UNUSED          2'b00
`define MODE_EVENT           2'b01
`define MODE_TIMER           2'b10
`define MODE_PULSE           2'b11

// Prescaler
`define PRESCALE_LAST        2'b11

`endif

/* core/input_edge_sync.v */
`timescale 1ns/1ns
`default_nettype none
module input_edge_sync (
    input  wire clk,
    input  wire rst_b,
    input  wire pin,
    output reg  level,
    output wire rise,
    output wire fall
);
    reg stage1;
    reg stage2;

    // Two-flop synchroniser, then edge detection on the clean copy
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            level  <= 1'b0;
        end else begin
            stage1 <= pin;
            stage2 <= stage1;
            level  <= stage2;
        end
    end

    assign rise = stage2 & ~level;
    assign fall = ~stage2 & level;
endmodule
`default_nettype wire

/* core/count_channel.v */
`timescale 1ns/1ns
`default_nettype none
`include "dual_timer_regs.vh"
module count_channel #(
    parameter WIDTH = 8
) (
    input  wire             clk,
    input  wire             rst_b,
    input  wire [7:0]       control,
    input  wire             tick,
    input  wire             pin_level,
    input  wire             pin_rise,
    input  wire             pin_fall,
    input  wire             hold,
    input  wire             preload_we,
    input  wire [WIDTH-1:0] preload_data,
    output reg  [WIDTH-1:0] count,
    output reg  [WIDTH-1:0] preload,
    output wire             overflow,
    output wire             pulse_done
);
    wire [1:0] mode;
    wire       run;
    wire       edge_fall;
    wire       active_edge;
    wire       back_edge;
    wire       step;
    reg        measuring;

    assign mode        = control[`CTL_MODE_MSB:`CTL_MODE_LSB];
    assign run         = control[`CTL_RUN_BIT];
    assign edge_fall   = control[`CTL_EDGE_BIT];
    assign active_edge = edge_fall ? pin_fall : pin_rise;
    assign back_edge   = edge_fall ? pin_rise : pin_fall;

    // Count enable per mode; a CPU read of the count blocks it
    assign step = run & ~hold & (
        (mode == `MODE_EVENT && active_edge) ||
        (mode == `MODE_TIMER && tick) ||
        (mode == `MODE_PULSE && measuring && tick));

    assign overflow   = step & (&count);
    assign pulse_done = (mode == `MODE_PULSE) & run & measuring
                        & back_edge;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            measuring <= 1'b0;
        end else if (mode != `MODE_PULSE || !run) begin
            measuring <= 1'b0;
        end else if (pulse_done) begin
            measuring <= 1'b0;
        end else if (active_edge) begin
            measuring <= 1'b1;
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count   <= {WIDTH{1'b0}};
            preload <= {WIDTH{1'b0}};
        end else begin
            if (preload_we)
                preload <= preload_data;
            if (preload_we && !run)
                count <= preload_data;
            else if (overflow)
                count <= preload;
            else if (step)
                count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
endmodule
`default_nettype wire

/* verification/dual_timer_event_counter_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module timer_checker (
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic [7:0] bus_addr,
    input wire logic       bus_rd,
    input wire logic [7:0] bus_rdata,
    input wire logic       short_irq_enable,
    input wire logic       wide_irq_enable,
    input wire logic       short_overflow_clear,
    input wire logic       wide_overflow_clear,
    input wire logic       short_overflow_flag,
    input wire logic       wide_overflow_flag,
    input wire logic       short_irq,
    input wire logic       wide_irq,
    input wire logic       wake_up
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    short_irq_a: assert property (
        short_irq == (short_overflow_flag && short_irq_enable))
        else $error("bad short irq");
    wide_irq_a: assert property (
        wide_irq == (wide_overflow_flag && wide_irq_enable))
        else $error("bad wide irq");
    wake_flag_a: assert property (
        wake_up |=> short_overflow_flag || wide_overflow_flag)
        else $error("wake without flag");
    short_rise_a: assert property (
        $rose(short_overflow_flag) |-> $past(wake_up))
        else $error("short flag without wake");
    wide_rise_a: assert property (
        $rose(wide_overflow_flag) |-> $past(wake_up))
        else $error("wide flag without wake");
    flag_keep_a: assert property (
        short_overflow_flag && !short_overflow_clear |=> short_overflow_flag)
        else $error("short flag lost");
    wide_clear_a: assert property (
        wide_overflow_clear && !wake_up |=> !wide_overflow_flag)
        else $error("wide flag not cleared");
    rdata_hold_a: assert property (
        !bus_rd |=> $stable(bus_rdata))
        else $error("read data moved");
    ctl_zero_a: assert property (
        bus_rd && (bus_addr == 8'h0e || bus_addr == 8'h11)
        |=> (bus_rdata & 8'h27) == 8'h00) else $error("unused bits set");
endmodule
bind dual_timer_event_counter timer_checker timer_checker_i (
    .clk, .rst_b, .bus_addr, .bus_rd, .bus_rdata, .short_irq_enable,
    .wide_irq_enable, .short_overflow_clear, .wide_overflow_clear,
    .short_overflow_flag, .wide_overflow_flag, .short_irq, .wide_irq,
    .wake_up);
`default_nettype wire

/* verification/event_source.sv */
`timescale 1ns/1ns
`default_nettype none
module event_source (
    input  wire logic clk,
    output var  logic short_counter_pin,
    output var  logic wide_counter_pin
);
    initial begin
        short_counter_pin = 1'b0;
        wide_counter_pin  = 1'b0;
    end
    // Set one pin at an edge, then hold it n cycles
    task automatic drive(input logic w, input logic v, input int n);
        @(posedge clk);
        if (w)
            wide_counter_pin <= v;
        else
            short_counter_pin <= v;
        repeat (n) @(posedge clk);
    endtask
endmodule
`default_nettype wire

/* verification/dual_timer_event_counter_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module dual_timer_event_counter_bench;
    logic       clk, rst_b, bus_wr, bus_rd, wake_up;
    logic [7:0] bus_addr, bus_wdata, bus_rdata, d, m;
    logic       short_counter_pin, short_irq_enable, short_overflow_clear;
    logic       wide_counter_pin, wide_irq_enable, wide_overflow_clear;
    logic       short_overflow_flag, wide_overflow_flag, short_irq, wide_irq;
    int         fails, total_checks;

    dual_timer_event_counter dual_timer_event_counter_i (
        .clk, .rst_b, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
        .short_counter_pin, .wide_counter_pin, .short_irq_enable,
        .wide_irq_enable, .short_overflow_clear, .wide_overflow_clear,
        .short_overflow_flag, .wide_overflow_flag, .short_irq, .wide_irq,
        .wake_up);
    event_source event_source_i (.clk, .short_counter_pin, .wide_counter_pin);

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        bus_addr  <= a;
        bus_wdata <= v;
        bus_wr    <= 1'b1;
        @(posedge clk);
        bus_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge clk);
        bus_rd   <= 1'b0;
        #1 d = bus_rdata;
    endtask
    task automatic wait_flag(input logic w);
        int n = 0;
        while ((w ? wide_overflow_flag : short_overflow_flag) !== 1'b1) begin
            @(posedge clk);
            n++;
            if (n > 200) begin
                fails++;
                end_of_test();
            end
        end
    endtask
    task automatic pin(input logic w, input logic v, input int n);
        event_source_i.drive(w, v, n);
    endtask

    task automatic t_regs;
        wr(8'h0e, 8'hff);
        rd(8'h0e);
        check(d, 8'hd8);
        wr(8'h11, 8'hf7);
        rd(8'h11);
        check(d, 8'hd0);
        wr(8'h0e, 8'h00);
        wr(8'h11, 8'h00);
        rd(8'h12);
        check(d, 8'h00);
    endtask
    task automatic t_timer;
        wr(8'h0d, 8'hfe);
        rd(8'h0d);
        check(d, 8'hfe);
        wr(8'h0e, 8'h90);
        wr(8'h0d, 8'h80);
        wait_flag(1'b0);
        check(short_irq, 1'b1);
        rd(8'h0e);
        check(d, 8'h90);
        wr(8'h0e, 8'h00);
        rd(8'h0d);
        check(d & 8'hf0, 8'h80);
        @(posedge clk);
        short_irq_enable <= 1'b0;
        @(posedge clk);
        #1 check(short_irq, 1'b0);
        check(short_overflow_flag, 1'b1);
        @(posedge clk);
        short_overflow_clear <= 1'b1;
        @(posedge clk);
        short_overflow_clear <= 1'b0;
        short_irq_enable     <= 1'b1;
        #1 check(short_overflow_flag, 1'b0);
    endtask
    task automatic t_wide;
        wr(8'h10, 8'h34);
        rd(8'h0f);
        rd(8'h10);
        check(d, 8'h00);
        wr(8'h10, 8'h34);
        wr(8'h0f, 8'h12);
        rd(8'h0f);
        check(d, 8'h12);
        rd(8'h10);
        check(d, 8'h34);
        wr(8'h10, 8'h55);
        rd(8'h10);
        check(d, 8'h55);
        wr(8'h10, 8'hfe);
        wr(8'h0f, 8'hff);
        wr(8'h11, 8'h90);
        wait_flag(1'b1);
        check(wide_irq, 1'b1);
        rd(8'h0f);
        check(d, 8'hff);
        wr(8'h11, 8'h00);
        wide_overflow_clear <= 1'b1;
        @(posedge clk);
        wide_overflow_clear <= 1'b0;
        #1 check(wide_overflow_flag, 1'b0);
    endtask
    task automatic t_event;
        wr(8'h0d, 8'h00);
        wr(8'h0e, 8'h50);
        repeat (3) begin
            pin(1'b0, 1'b1, 4);
            pin(1'b0, 1'b0, 4);
        end
        rd(8'h0d);
        check(d, 8'h03);
        wr(8'h0e, 8'h58);
        pin(1'b0, 1'b1, 8);
        rd(8'h0d);
        check(d, 8'h03);
        pin(1'b0, 1'b0, 8);
        rd(8'h0d);
        check(d, 8'h04);
        // Unused mode with run set must not count
        wr(8'h0e, 8'h10);
        pin(1'b0, 1'b1, 8);
        pin(1'b0, 1'b0, 8);
        rd(8'h0d);
        check(d, 8'h04);
        wr(8'h0e, 8'h00);
    endtask
    task automatic t_pulse;
        wr(8'h10, 8'h00);
        wr(8'h0f, 8'h00);
        wr(8'h11, 8'hd0);
        pin(1'b1, 1'b1, 40);
        pin(1'b1, 1'b0, 8);
        rd(8'h11);
        check(d, 8'hc0);
        rd(8'h0f);
        rd(8'h10);
        m = d;
        check(d >= 8'h09 && d <= 8'h0b, 1'b1);
        pin(1'b1, 1'b1, 20);
        pin(1'b1, 1'b0, 8);
        rd(8'h0f);
        rd(8'h10);
        check(d, m);
        wr(8'h11, 8'hd0);
        pin(1'b1, 1'b1, 20);
        pin(1'b1, 1'b0, 8);
        rd(8'h0f);
        rd(8'h10);
        check(d > m, 1'b1);
    endtask

    initial begin
        rst_b = 1'b0;
        bus_addr = 8'h00;
        bus_wdata = 8'h00;
        {bus_wr, bus_rd, short_overflow_clear, wide_overflow_clear} = 4'h0;
        {short_irq_enable, wide_irq_enable} = 2'h3;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        t_regs();
        t_timer();
        t_wide();
        t_event();
        t_pulse();
        end_of_test();
    end
endmodule
`default_nettype wire
